//--- hdl/fdcr_regs.sv
// Floppy controller tape select, main status and rate registers behind Wishbone.
// Assumes status inputs come from the command machine on clk_sys and that
// the data register itself lives elsewhere; only its accesses are seen here.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fdcr_params.svh"

module fdcr_regs #(
	parameter int ADR_W   = 8,
	parameter int TRACK_W = 8
) (
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	// wishbone classic slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [ADR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	// controller state shown in main status
	input  wire logic               host_transfer_ready,
	input  wire logic               transfer_direction,
	input  wire logic               non_dma_flag,
	input  wire logic               command_busy,
	input  wire logic               drive_b_seeking,
	input  wire logic               drive_a_seeking,
	// controller_config_command command and current track
	input  wire logic               cfg_track_load,
	input  wire logic [TRACK_W-1:0] cfg_track_value,
	input  wire logic [TRACK_W-1:0] current_track,
	// controls toward the controller core
	output logic                    core_reset_r,
	output logic                    clocks_stopped_r,
	output logic      [1:0]         rate_field_r,
	output logic      [2:0]         precomp_code_r,
	output logic      [17:0]        precomp_delay_ps_r,
	output logic      [TRACK_W-1:0] precomp_start_track_r,
	output logic                    precomp_enable_r,
	output logic                    data_access_r
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADR_W < 5) begin : g_adr_check
		$error("fdcr_regs: ADR_W must be at least 5");
	end
	if (TRACK_W < 1 || TRACK_W > 16) begin : g_track_check
		$error("fdcr_regs: TRACK_W must be 1 to 16");
	end

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// effective delay for a precomp code at a given rate
	function automatic logic [17:0] precomp_ps(input logic [2:0] code,
		input logic [1:0] rate);
		logic [17:0] ps;
		ps = `FDCR_PRECOMP_PS_0;
		unique case (code)
			3'h0: begin
				if (rate == fdcr_pkg::FDCR_RATE_1M) begin
					ps = `FDCR_PRECOMP_PS_1;
				end else begin
					ps = `FDCR_PRECOMP_PS_3;
				end
			end
			3'h1: ps = `FDCR_PRECOMP_PS_1;
			3'h2: ps = `FDCR_PRECOMP_PS_2;
			3'h3: ps = `FDCR_PRECOMP_PS_3;
			3'h4: ps = `FDCR_PRECOMP_PS_4;
			3'h5: ps = `FDCR_PRECOMP_PS_5;
			3'h6: ps = `FDCR_PRECOMP_PS_6;
			3'h7: ps = `FDCR_PRECOMP_PS_0;
		endcase
		return ps;
	endfunction

	// word index hit, upper address bits must be zero
	function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [2:0] idx);
		return (adr[1:0] == 2'h0) && (adr[4:2] == idx) && ((adr >> 5) == '0);
	endfunction

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic req;
	logic wr;
	logic rd;
	logic lane0;
	logic hit_out;
	logic hit_tape;
	logic hit_sr;
	logic hit_data;
	logic hit_dcr;

	// a request is acted on in the cycle ack is being raised
	assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign lane0    = wb_sel_i[0];
	assign wr       = req & wb_we_i & lane0;
	assign rd       = req & ~wb_we_i;
	assign hit_out  = idx_hit(wb_adr_i, `FDCR_IDX_OUTPUT_CTRL);
	assign hit_tape = idx_hit(wb_adr_i, `FDCR_IDX_TAPE_SELECT);
	assign hit_sr   = idx_hit(wb_adr_i, `FDCR_IDX_STATUS_RATE);
	assign hit_data = idx_hit(wb_adr_i, `FDCR_IDX_DATA);
	assign hit_dcr  = idx_hit(wb_adr_i, `FDCR_IDX_RATE_CTRL);

	// ----------------------------------------------------------------
	// stored registers
	// ----------------------------------------------------------------
	logic [7:0] outctrl_r;
	logic [1:0] tape_sel_r;
	logic [7:0] rate_sel_r;
	logic [1:0] rate_nxt;
	logic       sw_reset_r;
	logic [7:0] status_nxt;

	// output control: only the hardware reset touches it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			outctrl_r <= `FDCR_OUTCTRL_RESET;
		end else if (wr && hit_out) begin
			outctrl_r <= wb_dat_i[7:0] & `FDCR_OUTCTRL_MASK;
		end
	end

	// tape select: stored for readback only, feeds no other logic
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tape_sel_r <= 2'h0;
		end else if (wr && hit_tape) begin
			tape_sel_r <= wb_dat_i[1:0];
		end
	end

	// rate select: bit 7 is never stored, it becomes a one-cycle pulse
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rate_sel_r <= `FDCR_RATE_RESET;
		end else if (wr && hit_sr) begin
			rate_sel_r <= {1'b0, wb_dat_i[6:0]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sw_reset_r <= 1'b0;
		end else begin
			sw_reset_r <= wr & hit_sr & wb_dat_i[`FDCR_RATE_SWRST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// active rate: last writer of either register wins
	// ----------------------------------------------------------------
	always_comb begin
		rate_nxt = rate_field_r;
		if (wr && hit_sr) begin
			rate_nxt = wb_dat_i[1:0];
		end else if (wr && hit_dcr) begin
			rate_nxt = wb_dat_i[1:0];
		end
	end

	// software reset deliberately absent here, so rate survives it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rate_field_r <= 2'(`FDCR_RATE_RESET);
		end else begin
			rate_field_r <= rate_nxt;
		end
	end

	// ----------------------------------------------------------------
	// precompensation
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			precomp_code_r     <= `FDCR_PRECOMP_DEFAULT;
			precomp_delay_ps_r <= `FDCR_PRECOMP_PS_3;
		end else begin
			precomp_code_r     <= rate_sel_r[4:2];
			precomp_delay_ps_r <= precomp_ps(rate_sel_r[4:2], rate_field_r);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			precomp_start_track_r <= TRACK_W'(`FDCR_PRECOMP_TRACK0);
		end else if (cfg_track_load) begin
			precomp_start_track_r <= cfg_track_value;
		end
	end

	// a zero delay code leaves precomp off regardless of track
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			precomp_enable_r <= 1'b0;
		end else begin
			precomp_enable_r <= (current_track >= precomp_start_track_r) &&
				(precomp_delay_ps_r != `FDCR_PRECOMP_PS_0);
		end
	end

	// ----------------------------------------------------------------
	// controller reset and power down
	// ----------------------------------------------------------------
	// hardware reset leaves the output reset bit low, so the core stays held
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			core_reset_r <= 1'b1;
		end else begin
			core_reset_r <= ~outctrl_r[`FDCR_OUTCTRL_RSTN_BIT] | sw_reset_r;
		end
	end

	// wake beats entry: a reset or access in the same write clears it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			clocks_stopped_r <= 1'b0;
		end else if (sw_reset_r || core_reset_r || (req && hit_data) || (rd && hit_sr)) begin
			clocks_stopped_r <= 1'b0;
		end else if (wr && hit_sr && wb_dat_i[`FDCR_RATE_PDOWN_BIT] &&
			!wb_dat_i[`FDCR_RATE_SWRST_BIT]) begin
			clocks_stopped_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			data_access_r <= 1'b0;
		end else begin
			data_access_r <= req & hit_data;
		end
	end

	// ----------------------------------------------------------------
	// main status and read mux
	// ----------------------------------------------------------------
	// direction only meaningful while ready, so it is masked otherwise
	assign status_nxt = {host_transfer_ready,
		host_transfer_ready & transfer_direction,
		non_dma_flag,
		command_busy,
		2'h0,
		drive_b_seeking,
		drive_a_seeking};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// write-only and unmapped words read as zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			if (hit_sr) begin
				wb_dat_o <= {24'h00_0000, status_nxt};
			end else if (hit_tape) begin
				wb_dat_o <= {30'h0000_0000, tape_sel_r};
			end else if (hit_out) begin
				wb_dat_o <= {24'h00_0000, outctrl_r};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

endmodule

//--- hdl/fdcr_params.svh
// Operation
// - tape select register at index 03h is read/write but drives nothing inside.
// - tape select bits 1-0 pick none or drive 1 to 3; bits 7-2 undefined.
// - read-only main status register at index 04h reports controller status.
// - status bit 7 is 0 while busy, 1 when host may transfer data.
// - status bit 6 gives direction once ready: 0 host writes, 1 host reads.
// - status bit 5 is 1 in non-DMA mode, 0 in DMA mode.
// - status bit 4 is 1 while a command runs, 0 after result phase end.
// - status bit 1 is 1 while drive B is seeking.
// - status bit 0 is 1 while drive A is seeking.
// - write-only rate register at index 04h sets rate, precomp, power down, reset.
// - active data rate follows whichever of rate or diskette control was last written.
// - software reset leaves the rate register unchanged.
// - hardware reset loads the rate register with 02h: default precomp, 250 Kbps.
// - rate register bit 7 resets the controller like the output reset bit, self-clearing.
// - rate register bit 6 stops clocks until software reset, data or status access.
// - bits 4-2 pick precomp delay; 111 none, 001-110 steps, 000 rate default.
// - precomp starts at track 0 by default; controller_config_command command may change it.
// - bits 1-0 pick 500K, 300K, 250K or 1M; data separator clock follows.
// - the output register reset never alters rate, diskette control or output registers.
//
// Header of register indices, field positions, reset values and timing figures.
// Assumes a byte-wide register file on a 32-bit Wishbone bus, one word per index.
`ifndef FDCR_PARAMS_SVH
`define FDCR_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FDCR_IDX_OUTPUT_CTRL   3'h2
`define FDCR_IDX_TAPE_SELECT   3'h3
`define FDCR_IDX_STATUS_RATE   3'h4
`define FDCR_IDX_DATA          3'h5
`define FDCR_IDX_RATE_CTRL     3'h7

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FDCR_RATE_RESET        8'h02
`define FDCR_OUTCTRL_RESET     8'h00
`define FDCR_OUTCTRL_MASK      8'h3D
`define FDCR_TAPE_MASK         8'h03
`define FDCR_RATE_SWRST_BIT    7
`define FDCR_RATE_PDOWN_BIT    6
`define FDCR_OUTCTRL_RSTN_BIT  2
`define FDCR_PRECOMP_NONE      3'h7
`define FDCR_PRECOMP_DEFAULT   3'h0
`define FDCR_PRECOMP_TRACK0    8'h00

// ----------------------------------------------------------------
// precompensation delays in picoseconds
// ----------------------------------------------------------------
`define FDCR_PRECOMP_PS_0      18'd0
`define FDCR_PRECOMP_PS_1      18'd41700
`define FDCR_PRECOMP_PS_2      18'd83300
`define FDCR_PRECOMP_PS_3      18'd125000
`define FDCR_PRECOMP_PS_4      18'd166700
`define FDCR_PRECOMP_PS_5      18'd208300
`define FDCR_PRECOMP_PS_6      18'd250000

`endif

//--- hdl/fdcr_pkg.sv
// Types shared by the floppy status and rate register bank.
// Assumes the constants header is included where offsets are needed.
package fdcr_pkg;

	// ----------------------------------------------------------------
	// data rate encoding
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FDCR_RATE_500K = 2'h0,
		FDCR_RATE_300K = 2'h1,
		FDCR_RATE_250K = 2'h2,
		FDCR_RATE_1M   = 2'h3
	} fdcr_rate_t;

endpackage

//--- sim/fdcr_regs_props.sv
// checker for the floppy status and rate register bank
// sees only the top ports; bound to every fdcr_regs at the foot
`timescale 1ns/1ps
module fdcr_regs_props #(
	parameter int ADR_W = 8
) (
	input wire logic             clk_sys,
	input wire logic             sys_rst,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]       wb_sel_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             host_transfer_ready,
	input wire logic             transfer_direction,
	input wire logic             non_dma_flag,
	input wire logic             command_busy,
	input wire logic             drive_b_seeking,
	input wire logic             drive_a_seeking,
	input wire logic             core_reset_r,
	input wire logic             clocks_stopped_r,
	input wire logic [1:0]       rate_field_r
);
	logic req, rd_st, wr_rate, wr_dcr;
	// a request counts once: ack low marks its first edge
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_st = req && !wb_we_i && wb_adr_i == ADR_W'(8'h10);
	assign wr_rate = req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_W'(8'h10);
	assign wr_dcr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_W'(8'h1C);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_ack_one_cycle: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse one cycle after request");
	a_ready_bit: assert property (rd_st |=> wb_dat_o[7] == $past(host_transfer_ready))
		else $error("status ready bit wrong");
	a_dir_bit: assert property (rd_st |=> wb_dat_o[6] == $past(host_transfer_ready && transfer_direction))
		else $error("status direction bit wrong");
	a_mode_busy: assert property (rd_st |=> wb_dat_o[5:4] == $past({non_dma_flag, command_busy}))
		else $error("status mode or busy bit wrong");
	a_seek_bits: assert property (rd_st |=> wb_dat_o[3:0] == {2'b00, $past(drive_b_seeking), $past(drive_a_seeking)})
		else $error("status seek bits wrong");
	a_rate_follow: assert property (wr_rate || wr_dcr |=> rate_field_r == $past(wb_dat_i[1:0]))
		else $error("active rate not the last written");
	a_pdown_enter: assert property (wr_rate && wb_dat_i[7:6] == 2'b01 && !core_reset_r |=> clocks_stopped_r)
		else $error("power down not entered");
	a_pdown_wake: assert property (clocks_stopped_r && rd_st |-> ##[1:2] !clocks_stopped_r)
		else $error("status read did not wake clocks");
	a_swrst_pulse: assert property (wr_rate && wb_dat_i[7] |-> ##[1:3] core_reset_r)
		else $error("software reset bit did not reset core");
endmodule

bind fdcr_regs fdcr_regs_props #(.ADR_W(ADR_W)) fdcr_regs_props_i (.clk_sys, .sys_rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.host_transfer_ready, .transfer_direction, .non_dma_flag, .command_busy, .drive_b_seeking,
	.drive_a_seeking, .core_reset_r, .clocks_stopped_r, .rate_field_r);

//--- sim/fdcr_host.sv
// host processor model: classic Wishbone master with one access task
// assumes the slave acks every request; hung rises if it never does
`timescale 1ns/1ps
module fdcr_host (
	input  wire logic        clk_sys,
	output logic             wb_cyc_i,
	output logic             wb_stb_i,
	output logic             wb_we_i,
	output logic [7:0]       wb_adr_i,
	output logic [3:0]       wb_sel_i,
	output logic [31:0]      wb_dat_i,
	input  wire logic        wb_ack_o,
	input  wire logic [31:0] wb_dat_o,
	output logic             hung
);
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, hung} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
	end
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		if (wb_ack_o !== 1'b1)
			hung <= 1'b1;
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		// released address and data lines show the inverse, never a stale value; select stays at F
		wb_adr_i <= ~a;
		wb_dat_i <= ~{24'h0, d};
	endtask
endmodule

//--- sim/fdcr_regs_tb_top.sv
// self-checking bench for the floppy status and rate register bank
// assumes fdcr_host as bus master and the checker bound in its own file
`timescale 1ns/1ps
`include "fdcr_params.svh"
module fdcr_regs_tb_top;
	typedef struct packed {
		logic [7:0]  a;
		logic [7:0]  d;
		logic [1:0]  r;
		logic [17:0] p;
	} fdcr_row_t;
	logic        clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hung;
	logic        core_reset_r, clocks_stopped_r, cfg_track_load;
	logic        precomp_enable_r, data_access_r;
	logic [7:0]  cfg_track_value, current_track, precomp_start_track_r;
	logic [2:0]  precomp_code_r;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [5:0]  st;
	logic [1:0]  rate_field_r;
	logic [17:0] precomp_delay_ps_r;
	int          err_total, n_tests, n_data;
	// rate writes: address, data, expected rate, expected delay
	fdcr_row_t rows [12] = '{
		'{8'h10, 8'h00, 2'h0, `FDCR_PRECOMP_PS_3}, '{8'h10, 8'h01, 2'h1, `FDCR_PRECOMP_PS_3},
		'{8'h10, 8'h03, 2'h3, `FDCR_PRECOMP_PS_1}, '{8'h10, 8'h04, 2'h0, `FDCR_PRECOMP_PS_1},
		'{8'h10, 8'h08, 2'h0, `FDCR_PRECOMP_PS_2}, '{8'h10, 8'h0C, 2'h0, `FDCR_PRECOMP_PS_3},
		'{8'h10, 8'h10, 2'h0, `FDCR_PRECOMP_PS_4}, '{8'h10, 8'h14, 2'h0, `FDCR_PRECOMP_PS_5},
		'{8'h10, 8'h18, 2'h0, `FDCR_PRECOMP_PS_6}, '{8'h10, 8'h1C, 2'h0, `FDCR_PRECOMP_PS_0},
		'{8'h1C, 8'h01, 2'h1, `FDCR_PRECOMP_PS_0}, '{8'h10, 8'h1B, 2'h3, `FDCR_PRECOMP_PS_6}};
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	fdcr_regs fdcr_regs_i (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_transfer_ready(st[5]),
		.transfer_direction(st[4]), .non_dma_flag(st[3]), .command_busy(st[2]),
		.drive_b_seeking(st[1]), .drive_a_seeking(st[0]), .cfg_track_load, .cfg_track_value,
		.current_track, .core_reset_r, .clocks_stopped_r, .rate_field_r, .precomp_code_r,
		.precomp_delay_ps_r, .precomp_start_track_r, .precomp_enable_r, .data_access_r);
	fdcr_host fdcr_host_i (.clk_sys, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_ack_o, .wb_dat_o, .hung);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("errors=%0d checks=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge hung) begin
		err_total++;
		wrap_up();
	end
	// the access pulse stands one cycle; count it mid-cycle, away from the edge
	always @(negedge clk_sys) begin
		if (data_access_r === 1'b1)
			n_data++;
	end
	initial begin
		int n;
		sys_rst = 1'b1;
		st = 6'h00;
		cfg_track_load = 1'b0;
		cfg_track_value = 8'h00;
		current_track = 8'h00;
		n_data = 0;
		err_total = 0;
		n_tests = 0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(32'(rate_field_r), 32'h2);
		chk(32'(precomp_delay_ps_r), 32'(`FDCR_PRECOMP_PS_3));
		chk(32'(precomp_code_r), 32'h0);
		chk(32'(core_reset_r), 32'h1);
		chk(32'(clocks_stopped_r), 32'h0);
		chk(32'(precomp_start_track_r), 32'h0);
		chk(32'(precomp_enable_r), 32'h1);
		foreach (rows[i]) begin
			fdcr_host_i.acc(1'b1, rows[i].a, rows[i].d, q);
			repeat (2) @(posedge clk_sys);
			#1;
			chk(32'(rate_field_r), 32'(rows[i].r));
			chk(32'(precomp_delay_ps_r), 32'(rows[i].p));
			chk(32'(precomp_enable_r), 32'(rows[i].p != 18'd0));
		end
		chk(32'(precomp_code_r), 32'h6);
		// move the precomp start track, then cross it
		@(posedge clk_sys);
		cfg_track_value <= 8'h28;
		cfg_track_load  <= 1'b1;
		current_track   <= 8'h10;
		@(posedge clk_sys);
		cfg_track_load <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(precomp_start_track_r), 32'h28);
		chk(32'(precomp_enable_r), 32'h0);
		@(posedge clk_sys);
		current_track <= 8'h30;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(precomp_enable_r), 32'h1);
		for (int i = 0; i < 64; i += 9) begin
			@(posedge clk_sys);
			st <= 6'(i);
			fdcr_host_i.acc(1'b0, 8'h10, 8'h00, q);
			chk(q, {24'h0, st[5], st[5] & st[4], st[3:2], 2'b00, st[1:0]});
		end
		for (int v = 0; v < 4; v++) begin
			fdcr_host_i.acc(1'b1, 8'h0C, 8'(v) | 8'hFC, q);
			fdcr_host_i.acc(1'b0, 8'h0C, 8'h00, q);
			chk(q & 32'h3, 32'(v));
		end
		chk(32'(rate_field_r), 32'h3);
		fdcr_host_i.acc(1'b0, 8'h18, 8'h00, q);
		chk(q, 32'h0);
		// leave the output-control reset so the core can run
		fdcr_host_i.acc(1'b1, 8'h08, 8'h04, q);
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(core_reset_r), 32'h0);
		fdcr_host_i.acc(1'b1, 8'h10, 8'h81, q);
		#1;
		n = 0;
		while (core_reset_r !== 1'b1 && n < 8) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(32'(core_reset_r), 32'h1);
		repeat (3) @(posedge clk_sys);
		#1;
		chk(32'(core_reset_r), 32'h0);
		chk(32'(rate_field_r), 32'h1);
		fdcr_host_i.acc(1'b1, 8'h10, 8'h42, q);
		#1;
		chk(32'(clocks_stopped_r), 32'h1);
		fdcr_host_i.acc(1'b0, 8'h10, 8'h00, q);
		@(posedge clk_sys);
		#1;
		chk(32'(clocks_stopped_r), 32'h0);
		// host polls status before a data byte; that byte wakes a power down
		@(posedge clk_sys);
		st <= 6'h28;
		fdcr_host_i.acc(1'b0, 8'h10, 8'h00, q);
		chk(q, 32'hA0);
		fdcr_host_i.acc(1'b1, 8'h10, 8'h41, q);
		#1;
		chk(32'(clocks_stopped_r), 32'h1);
		fdcr_host_i.acc(1'b1, 8'h14, 8'h5A, q);
		#1;
		chk(32'(clocks_stopped_r), 32'h0);
		chk(32'(n_data), 32'h1);
		chk(32'(rate_field_r), 32'h1);
		// mid-run hardware reset brings the rate back to its default
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(32'(rate_field_r), 32'h2);
		chk(32'(core_reset_r), 32'h1);
		wrap_up();
	end
endmodule
